/* hdl/bca_accum.sv */
// current accumulators: net counter and lifetime charge/discharge totals
`timescale 1ns/1ps
module bca_accum #(
    parameter int MEAS_PERIOD = bca_pkg::MEAS_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire bca_pkg::bca_ctrl_type ctrl,
    input wire logic [bca_pkg::CUR_W-1:0] raw_current,
    input wire logic [bca_pkg::CUR_W-1:0] current_offset,
    input wire logic limit_wr,
    input wire logic [7:0] limit_wdata,
    input wire logic net_wr,
    input wire logic [7:0] net_wdata,
    input wire logic charge_wr,
    input wire bca_pkg::bca_total_bytes_type charge_wdata,
    input wire logic discharge_wr,
    input wire bca_pkg::bca_total_bytes_type discharge_wdata,
    output logic [7:0] small_signal_limit,
    output logic [bca_pkg::NET_W-1:0] net_charge_counter,
    output bca_pkg::bca_total_bytes_type lifetime_charge_total,
    output bca_pkg::bca_total_bytes_type lifetime_discharge_total,
    output logic signed [bca_pkg::COR_W-1:0] corrected_current,
    output logic totals_page_busy,
    output logic nvm_copy_req
);
    localparam int RW = bca_pkg::RES_W;
    localparam int COR_W = bca_pkg::COR_W;

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    // threshold code to magnitude in lsb
    function automatic logic [3:0] limit_value(input logic [7:0] b);
        logic [1:0] code;
        code = {b[bca_pkg::LIM_HI_BIT], b[bca_pkg::LIM_LO_BIT]};
        case (code)
            2'h0: limit_value = bca_pkg::LIM_NONE;
            2'h1: limit_value = bca_pkg::LIM_TWO;
            2'h2: limit_value = bca_pkg::LIM_FOUR;
            default: limit_value = bca_pkg::LIM_EIGHT;
        endcase
    endfunction

    // add magnitude to a residue; returns carry in bit RW
    function automatic logic [RW:0] res_add(input logic [RW-1:0] r,
                                            input logic [RW-1:0] m,
                                            input logic [RW-1:0] s);
        logic [RW-1:0] sum;
        sum = r + m;
        if (sum >= s) begin
            res_add = {1'b1, sum - s};
        end else begin
            res_add = {1'b0, sum};
        end
    endfunction

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    logic tick;
    logic [7:0] limit_reg, limit_next;
    logic [bca_pkg::NET_W-1:0] net_reg, net_next;
    logic [bca_pkg::TOT_W-1:0] chg_reg, chg_next, dis_reg, dis_next;
    logic [RW-1:0] net_res_reg, net_res_next;
    logic [RW-1:0] chg_res_reg, chg_res_next, dis_res_reg, dis_res_next;
    logic signed [bca_pkg::COR_W-1:0] cor_reg, cor_next;
    logic copy_next, busy_next;
    logic signed [bca_pkg::COR_W-1:0] cor;
    logic [bca_pkg::COR_W-1:0] mag;
    logic [RW-1:0] mag_w;
    logic accept, totals_run;
    logic [RW:0] r_net, r_chg, r_dis;
    logic [RW-1:0] res_dn;

    bca_tick #(
        .PERIOD(MEAS_PERIOD)
    ) u_tick (
        .clock(clock),
        .sys_rst(sys_rst),
        .run(ctrl.converter_on),
        .tick(tick)
    );

    // -------------------------------------------------------------
    // measurement conditioning
    // -------------------------------------------------------------
    // offset correction, sign gives direction, magnitude for filtering
    always_comb begin
        cor = COR_W'(signed'(raw_current)) + COR_W'(signed'(current_offset));
        mag = cor[COR_W-1] ? COR_W'(-cor) : COR_W'(cor);
        mag_w = RW'(mag);
        accept = tick && (mag > COR_W'(limit_value(limit_reg)));
        totals_run = ctrl.converter_on && ctrl.totals_on;
        r_net = res_add(net_res_reg, mag_w, bca_pkg::NET_SCALE);
        r_chg = res_add(chg_res_reg, mag_w, bca_pkg::TOT_SCALE);
        r_dis = res_add(dis_res_reg, mag_w, bca_pkg::TOT_SCALE);
        // borrow path for net residue on discharge
        res_dn = (net_res_reg >= mag_w) ? net_res_reg - mag_w
                 : net_res_reg + bca_pkg::NET_SCALE - mag_w;
    end

    // -------------------------------------------------------------
    // accumulator next-state
    // -------------------------------------------------------------
    // host writes win over accumulation in the same cycle
    always_comb begin
        limit_next = limit_reg;
        net_next = net_reg;
        chg_next = chg_reg;
        dis_next = dis_reg;
        net_res_next = net_res_reg;
        chg_res_next = chg_res_reg;
        dis_res_next = dis_res_reg;
        cor_next = tick ? cor : cor_reg;
        copy_next = 1'b0;
        busy_next = totals_run;
        // net counter only accumulates with the converter on
        if (accept && ctrl.converter_on) begin
            if (!cor[COR_W-1]) begin
                net_res_next = r_net[RW-1:0];
                if (r_net[RW] && net_reg != bca_pkg::NET_MAX) begin
                    net_next = net_reg + 8'h01;
                end
            end else begin
                net_res_next = res_dn;
                if (net_res_reg < mag_w && net_reg != bca_pkg::NET_RESET) begin
                    net_next = net_reg - 8'h01;
                end
            end
        end
        // totals wrap like plain counters and never clear on empty pack
        if (accept && totals_run) begin
            if (!cor[COR_W-1]) begin
                chg_res_next = r_chg[RW-1:0];
                if (r_chg[RW]) begin
                    chg_next = chg_reg + 16'h0001;
                    copy_next = ctrl.shadow_on;
                end
            end else begin
                dis_res_next = r_dis[RW-1:0];
                if (r_dis[RW]) begin
                    dis_next = dis_reg + 16'h0001;
                    copy_next = ctrl.shadow_on;
                end
            end
        end
        if (limit_wr) begin
            limit_next = limit_wdata & bca_pkg::LIMIT_MASK;
        end
        if (net_wr) begin
            net_next = net_wdata;
        end
        // page 07h bytes act as storage when totals are off
        if (charge_wr) begin
            chg_next = {charge_wdata.hi, charge_wdata.lo};
        end
        if (discharge_wr) begin
            dis_next = {discharge_wdata.hi, discharge_wdata.lo};
        end
    end

    // registers; totals restart at zero, restore is the host's job
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            limit_reg <= bca_pkg::LIMIT_RESET;
            net_reg <= bca_pkg::NET_RESET;
            chg_reg <= bca_pkg::TOT_RESET;
            dis_reg <= bca_pkg::TOT_RESET;
            net_res_reg <= bca_pkg::RES_RESET;
            chg_res_reg <= bca_pkg::RES_RESET;
            dis_res_reg <= bca_pkg::RES_RESET;
            cor_reg <= '0;
            nvm_copy_req <= 1'b0;
            totals_page_busy <= 1'b0;
        end else begin
            limit_reg <= limit_next;
            net_reg <= net_next;
            chg_reg <= chg_next;
            dis_reg <= dis_next;
            net_res_reg <= net_res_next;
            chg_res_reg <= chg_res_next;
            dis_res_reg <= dis_res_next;
            cor_reg <= cor_next;
            nvm_copy_req <= copy_next;
            totals_page_busy <= busy_next;
        end
    end

    // outputs straight from registers
    assign small_signal_limit = limit_reg;
    assign net_charge_counter = net_reg;
    assign lifetime_charge_total = {chg_reg[7:0], chg_reg[15:8]};
    assign lifetime_discharge_total = {dis_reg[7:0], dis_reg[15:8]};
    assign corrected_current = cor_reg;
endmodule

/* hdl/bca_pkg.sv */
// constants and types shared by the battery current accumulators
// Function
// - update accumulators once per measurement, every 27.46 ms
// - net follows signed value; charge total positive only, discharge negative
// - net counter is a scaled 8-bit volatile binary counter
// - net counter changes only while converter enable is 1; host net writes land whatever the enable
// - readings not above the threshold are dropped by all counters
// - threshold in top two bits, rest read 0; none, 2, 4, 8 LSB
// - threshold byte resets to 00h at power-on
// - charge total is a 16-bit read/write counter, advances on positive current
// - discharge total is a separate 16-bit counter of negative magnitude
// - three enable bits select off, net only, all, all with shadow
// - page 07h is free storage unless totals are enabled
// - totals copy to nonvolatile memory only when shadow bit is 1
// - totals keep their values when the net counter reaches zero
// - raw reading is summed with the signed offset before use
// - corrected value is two's complement, sign set means discharge
package bca_pkg;
    // -------------------------------------------------------------
    // widths and timing
    // -------------------------------------------------------------
    localparam int CUR_W = 10;
    localparam int COR_W = 11;
    localparam int NET_W = 8;
    localparam int TOT_W = 16;
    localparam real CLK_MHZ = 25.0;
    localparam real MEAS_PERIOD_MS = 27.46;
    localparam int MEAS_CYCLES = int'(MEAS_PERIOD_MS * CLK_MHZ * 1000.0);
    // -------------------------------------------------------------
    // scaling: reading-samples per visible lsb
    // -------------------------------------------------------------
    localparam int RES_W = 25;
    localparam logic [RES_W-1:0] NET_SCALE = 25'h0040036;
    localparam logic [RES_W-1:0] TOT_SCALE = 25'h08006C0;
    // -------------------------------------------------------------
    // threshold byte layout, counter limits and reset values
    // -------------------------------------------------------------
    localparam int LIM_LO_BIT = 6;
    localparam int LIM_HI_BIT = 7;
    localparam logic [7:0] LIMIT_RESET = 8'h00;
    localparam logic [7:0] LIMIT_MASK = 8'hC0;
    localparam logic [3:0] LIM_NONE = 4'h0;
    localparam logic [3:0] LIM_TWO = 4'h2;
    localparam logic [3:0] LIM_FOUR = 4'h4;
    localparam logic [3:0] LIM_EIGHT = 4'h8;
    localparam logic [NET_W-1:0] NET_RESET = 8'h00;
    localparam logic [NET_W-1:0] NET_MAX = 8'hFF;
    localparam logic [TOT_W-1:0] TOT_RESET = 16'h0000;
    localparam logic [RES_W-1:0] RES_RESET = 25'h0000000;

    typedef struct packed {
        logic converter_on;
        logic totals_on;
        logic shadow_on;
    } bca_ctrl_type;

    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
    } bca_total_bytes_type;
endpackage

/* hdl/bca_tick.sv */
// measurement period divider producing a one-cycle enable
`timescale 1ns/1ps
module bca_tick #(
    parameter int PERIOD = bca_pkg::MEAS_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic run,
    output logic tick
);
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic tick_next;

    // free count while converter runs, restart when stopped
    always_comb begin
        count_next = count_reg;
        tick_next = 1'b0;
        if (!run) begin
            count_next = '0;
        end else if (count_reg == 32'(PERIOD - 1)) begin
            count_next = '0;
            tick_next = 1'b1;
        end else begin
            count_next = count_reg + 32'h00000001;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            count_reg <= '0;
            tick <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick <= tick_next;
        end
    end
endmodule

/* dv/bca_accum_checker.sv */
// concurrent checks on the accumulator block ports
`timescale 1ns/1ps
module bca_accum_checker #(
    parameter int MEAS_PERIOD = 4
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire bca_pkg::bca_ctrl_type ctrl,
    input wire logic limit_wr,
    input wire logic [7:0] limit_wdata,
    input wire logic net_wr,
    input wire logic [7:0] net_wdata,
    input wire logic charge_wr,
    input wire bca_pkg::bca_total_bytes_type charge_wdata,
    input wire logic discharge_wr,
    input wire bca_pkg::bca_total_bytes_type discharge_wdata,
    input wire logic [7:0] small_signal_limit,
    input wire logic [bca_pkg::NET_W-1:0] net_charge_counter,
    input wire bca_pkg::bca_total_bytes_type lifetime_charge_total,
    input wire bca_pkg::bca_total_bytes_type lifetime_discharge_total,
    input wire logic totals_page_busy,
    input wire logic nvm_copy_req
);
    // -------------------------------------------------------------
    // properties
    // -------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // three idle cycles cover the tick pipeline still in flight
    sequence s_conv_off; !ctrl.converter_on [*3]; endsequence
    sequence s_tot_off; !ctrl.totals_on [*3]; endsequence
    sequence s_shadow_off; !ctrl.shadow_on [*3]; endsequence
    property p_limit; limit_wr |=> small_signal_limit ==
        ($past(limit_wdata) & bca_pkg::LIMIT_MASK); endproperty
    property p_net_wr; net_wr |=> net_charge_counter == $past(net_wdata);
    endproperty
    property p_chg_wr; charge_wr |=> lifetime_charge_total ==
        $past(charge_wdata); endproperty
    property p_dis_wr; discharge_wr |=> lifetime_discharge_total ==
        $past(discharge_wdata); endproperty
    property p_busy; 1'b1 |=> totals_page_busy ==
        $past(ctrl.converter_on & ctrl.totals_on); endproperty
    property p_hold; s_conv_off ##0 !net_wr |=> $stable(net_charge_counter);
    endproperty
    property p_tot_hold; s_tot_off ##0 !charge_wr |=>
        $stable(lifetime_charge_total); endproperty
    property p_no_copy; s_shadow_off |-> !nvm_copy_req; endproperty
    property p_pulse; nvm_copy_req |=> !nvm_copy_req; endproperty
    property p_step; !net_wr |=> net_charge_counter == $past(net_charge_counter)
        || net_charge_counter == $past(net_charge_counter) + 8'h01
        || net_charge_counter == $past(net_charge_counter) - 8'h01;
    endproperty
    a_limit: assert property (p_limit) else $error("limit byte wrong");
    a_net_wr: assert property (p_net_wr) else $error("net write lost");
    a_chg_wr: assert property (p_chg_wr) else $error("charge write");
    a_dis_wr: assert property (p_dis_wr) else $error("discharge write");
    a_busy: assert property (p_busy) else $error("page busy wrong");
    a_hold: assert property (p_hold) else $error("net moved while off");
    a_tot_hold: assert property (p_tot_hold) else $error("total moved");
    a_no_copy: assert property (p_no_copy) else $error("copy unasked");
    a_pulse: assert property (p_pulse) else $error("copy pulse long");
    a_step: assert property (p_step) else $error("net jumped");
endmodule

bind bca_accum bca_accum_checker #(.MEAS_PERIOD(MEAS_PERIOD)) u_chk (
    .clock(clock), .sys_rst(sys_rst), .ctrl(ctrl), .limit_wr(limit_wr),
    .limit_wdata(limit_wdata), .net_wr(net_wr), .net_wdata(net_wdata),
    .charge_wr(charge_wr), .charge_wdata(charge_wdata),
    .discharge_wr(discharge_wr), .discharge_wdata(discharge_wdata),
    .small_signal_limit(small_signal_limit),
    .net_charge_counter(net_charge_counter),
    .lifetime_charge_total(lifetime_charge_total),
    .lifetime_discharge_total(lifetime_discharge_total),
    .totals_page_busy(totals_page_busy), .nvm_copy_req(nvm_copy_req));

/* dv/bca_host_model.sv */
// host side: configuration bits and register write strobes
`timescale 1ns/1ps
module bca_host_model (
    input wire logic clock,
    output bca_pkg::bca_ctrl_type ctrl,
    output logic [3:0] wr_stb,
    output logic [15:0] wr_val
);
    initial begin
        ctrl = '0;
        wr_stb = 4'h0;
        wr_val = 16'h0000;
    end
    // mode change lands on one clock edge
    task automatic set_mode(input logic [2:0] m);
        @(posedge clock);
        ctrl <= bca_pkg::bca_ctrl_type'(m);
    endtask
    // sel 0 limit, 1 net, 2 charge, 3 discharge
    task automatic wr(input int sel, input logic [15:0] v);
        bca_pkg::bca_ctrl_type keep;
        keep = ctrl;
        @(posedge clock);
        ctrl.converter_on <= 1'b0;
        @(posedge clock);
        wr_stb <= 4'h1 << sel;
        wr_val <= v;
        @(posedge clock);
        wr_stb <= 4'h0;
        ctrl <= keep;
        // let the write settle so callers see the new value and mode
        #1;
    endtask
endmodule

/* dv/tb_battery_current_accumulators.sv */
// self-checking bench for the current accumulators
`timescale 1ns/1ps
module tb_battery_current_accumulators;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [9:0] raw = 10'h000;
    logic [9:0] ofs = 10'h000;
    bca_pkg::bca_ctrl_type ctrl;
    logic [3:0] stb;
    logic [15:0] val;
    logic [7:0] lim;
    logic [7:0] net;
    bca_pkg::bca_total_bytes_type chg;
    bca_pkg::bca_total_bytes_type dis;
    logic signed [10:0] cor;
    logic busy;
    logic copy;
    int err_count = 0;
    int cmp_count = 0;
    int copies = 0;
    int cycles = 0;
    always #20 clock = ~clock;
    bca_host_model host (.clock(clock), .ctrl(ctrl), .wr_stb(stb),
        .wr_val(val));
    // short period keeps the long integrations within the run budget
    bca_accum #(.MEAS_PERIOD(4)) dut (.clock(clock), .sys_rst(sys_rst),
        .ctrl(ctrl), .raw_current(raw), .current_offset(ofs),
        .limit_wr(stb[0]), .limit_wdata(val[7:0]), .net_wr(stb[1]),
        .net_wdata(val[7:0]), .charge_wr(stb[2]),
        .charge_wdata({val[7:0], val[15:8]}), .discharge_wr(stb[3]),
        .discharge_wdata({val[7:0], val[15:8]}),
        .small_signal_limit(lim), .net_charge_counter(net),
        .lifetime_charge_total(chg), .lifetime_discharge_total(dis),
        .corrected_current(cor), .totals_page_busy(busy),
        .nvm_copy_req(copy));
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // copy pulses counted; the cycle ceiling cuts a hang short
    always @(posedge clock) begin
        cycles++;
        if (copy === 1'b1) copies++;
        if (cycles == 80000) begin
            err_count++;
            report_and_stop();
        end
    end
    initial begin
        run(8);
        sys_rst <= 1'b0;
        run(1);
        chk("limit", 16'h0000, {8'h00, lim});
        chk("net", 16'h0000, {8'h00, net});
        for (int i = 0; i < 8; i++) begin
            host.set_mode(i[2:0]);
            run(2);
            chk("busy", {15'h0, i[2] & i[1]}, {15'h0, busy});
        end
        for (int i = 3; i >= 0; i--) begin
            host.wr(0, {8'h00, i[1:0], 6'h3F});
            chk("limit", {8'h00, i[1:0], 6'h00}, {8'h00, lim});
        end
        // +1022 per reading: about 8500 readings in the window
        raw <= 10'h1FF;
        ofs <= 10'h1FF;
        host.set_mode(3'b111);
        run(34000);
        chk("corrected", 16'h03FE, {5'h00, cor});
        chk("net", 16'h0021, {8'h00, net});
        chk("charge", 16'h0001, {chg.hi, chg.lo});
        chk("discharge", 16'h0000, {dis.hi, dis.lo});
        chk("copies", 16'h0001, copies[15:0]);
        host.set_mode(3'b011);
        run(400);
        chk("net", 16'h0021, {8'h00, net});
        raw <= 10'h201;
        ofs <= 10'h201;
        host.set_mode(3'b110);
        run(36000);
        chk("corrected", 16'h0402, {5'h00, cor});
        chk("net", 16'h0000, {8'h00, net});
        chk("discharge", 16'h0001, {dis.hi, dis.lo});
        chk("charge", 16'h0001, {chg.hi, chg.lo});
        chk("copies", 16'h0001, copies[15:0]);
        host.set_mode(3'b000);
        host.wr(1, 16'h00A5);
        chk("net", 16'h00A5, {8'h00, net});
        host.wr(2, 16'h1234);
        chk("charge", 16'h1234, {chg.hi, chg.lo});
        host.wr(3, 16'hBEEF);
        chk("discharge", 16'hBEEF, {dis.hi, dis.lo});
        report_and_stop();
    end
endmodule
